// ---- common/ledi2c_pkg.sv ----
// Constants, register map and state codes of the LED driver I2C slave
package ledi2c_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ = 40_000_000;
	localparam int SCL_MAX_HZ = 400_000;
	localparam int RAMP_STEP_US = 1000;
	localparam int ADC_REFRESH_US = 7000;
	localparam int RAMP_STEP_CYC = CLK_HZ / 1_000_000 * RAMP_STEP_US;
	localparam int ADC_REFRESH_CYC = CLK_HZ / 1_000_000 * ADC_REFRESH_US;
	localparam int NCH = 5;

	// ---------------------------------------------------------------
	// Slave address
	// ---------------------------------------------------------------
	localparam logic [6:0] ADDR_DEFAULT = 7'h55;
	localparam logic [6:0] ADDR_LOW = 7'h08;
	localparam logic [6:0] ADDR_HIGH = 7'h77;

	// ---------------------------------------------------------------
	// Register offsets and sizes in bytes
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_STORE = 8'h03;
	localparam logic [7:0] OFS_MIN_SUPPLY = 8'h22;
	localparam logic [7:0] OFS_LIMIT0 = 8'h30;
	localparam logic [7:0] OFS_READBACK0 = 8'h35;
	localparam logic [7:0] OFS_GOAL0 = 8'h3a;
	localparam logic [7:0] OFS_ADC0 = 8'h41;
	localparam logic [4:0] SZ_NONE = 5'h00;
	localparam logic [4:0] SZ_MIN_SUPPLY = 5'h04;
	localparam logic [4:0] SZ_LIMIT = 5'h02;
	localparam logic [4:0] SZ_READBACK = 5'h02;
	localparam logic [4:0] SZ_GOAL = 5'h04;
	localparam logic [4:0] SZ_ADC = 5'h02;
	localparam logic [3:0] BYTE_IDX_MAX = 4'hf;

	// ---------------------------------------------------------------
	// Fields and reset values
	// ---------------------------------------------------------------
	localparam int RATE_LSB = 0;
	localparam int RATE_MSB = 15;
	localparam int BRIGHT_LSB = 16;
	localparam int BRIGHT_MSB = 31;
	localparam int ADC_BITS = 10;
	localparam logic [5:0] ADC_PAD = 6'h00;
	localparam logic [31:0] RST_MIN_SUPPLY = 32'h00058000;
	localparam logic [15:0] RST_LIMIT = 16'h0000;
	localparam logic [31:0] RST_GOAL = 32'h00000000;

	// ---------------------------------------------------------------
	// Bus sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [9:0] {
		ST_IDLE = 10'h001,
		ST_ADDR = 10'h002,
		ST_ACK_ADDR = 10'h004,
		ST_REG = 10'h008,
		ST_ACK_REG = 10'h010,
		ST_WDATA = 10'h020,
		ST_ACK_W = 10'h040,
		ST_RDATA = 10'h080,
		ST_ACK_R = 10'h100,
		ST_WAIT = 10'h200
	} ledi2c_state_t;

endpackage

// ---- core/ledi2c_ramp.sv ----
// Per-channel brightness ramp and current computation
`timescale 1ns/100ps
module ledi2c_ramp (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	input wire logic enable,
	input wire logic [15:0] target,
	input wire logic [15:0] rate,
	input wire logic [15:0] limit,
	output logic [15:0] current
);

	typedef struct packed {
		logic [15:0] level;
		logic [15:0] current;
	} ledi2c_ramp_t;

	ledi2c_ramp_t s_reg;
	ledi2c_ramp_t s_next;
	logic [15:0] gap;
	logic [31:0] prod;

	// ---------------------------------------------------------------
	// Ramp toward target once per millisecond tick
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (s_reg.level > target) begin
			gap = s_reg.level - target;
		end else begin
			gap = target - s_reg.level;
		end
		prod = 32'(s_reg.level) * 32'(limit);
		if (tick) begin
			if (gap <= rate) begin
				s_next.level = target;
			end else if (s_reg.level < target) begin
				s_next.level = s_reg.level + rate;
			end else begin
				s_next.level = s_reg.level - rate;
			end
		end
		// Brightness is a fraction of the limit, so full scale is the limit
		if (enable) begin
			s_next.current = prod[31:16];
		end else begin
			s_next.current = 16'h0000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	assign current = s_reg.current;

endmodule

// ---- core/ledi2c_slave.sv ----
// I2C register slave of the five-channel LED driver
`timescale 1ns/100ps
module ledi2c_slave #(
	parameter int RAMP_CYC = ledi2c_pkg::RAMP_STEP_CYC,
	parameter int ADC_CYC = ledi2c_pkg::ADC_REFRESH_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic [6:0] addr_strap,
	input wire logic [31:0] supply_level,
	input wire logic [4:0][9:0] adc_value,
	output logic [4:0][15:0] channel_current,
	output logic led_enable,
	output logic low_power,
	output logic analog_supply_out
);

	typedef struct packed {
		logic scl_m;
		logic scl_s;
		logic scl_p;
		logic sda_m;
		logic sda_s;
		logic sda_p;
		logic [6:0] strap_m;
		logic [6:0] strap_s;
		logic [6:0] own_addr;
		ledi2c_pkg::ledi2c_state_t st;
		logic [2:0] cnt;
		logic done;
		logic [7:0] shift;
		logic rw;
		logic [7:0] ra;
		logic [3:0] bi;
		logic oe_n;
		logic [4:0][31:0] goal;
		logic [4:0][15:0] limit;
		logic [31:0] min_supply;
		logic [4:0][15:0] snap_limit;
		logic [31:0] snap_min;
		logic booted;
		logic [4:0][15:0] adc;
		logic [19:0] ramp_cnt;
		logic [19:0] adc_cnt;
		logic ramp_tick;
		logic led_en;
		logic low_pw;
		logic asup;
	} ledi2c_top_t;

	ledi2c_top_t s_reg;
	ledi2c_top_t s_next;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic [31:0] rv;
	logic [4:0] rsz;
	logic [3:0] pos;
	logic in_size;
	logic [7:0] rbyte;
	logic lum_zero;
	logic [5:0] adc_low;
	logic [4:0][15:0] cur;

	// ---------------------------------------------------------------
	// Decoding helpers
	// ---------------------------------------------------------------
	function automatic logic in_bank(input logic [7:0] a,
		input logic [7:0] base);
		return (a >= base) && (a < base + 8'(ledi2c_pkg::NCH));
	endfunction

	function automatic logic [2:0] bank_idx(input logic [7:0] a,
		input logic [7:0] base);
		return 3'(a - base);
	endfunction

	function automatic logic [4:0] reg_size(input logic [7:0] a);
		if (a == ledi2c_pkg::OFS_MIN_SUPPLY) begin
			return ledi2c_pkg::SZ_MIN_SUPPLY;
		end else if (in_bank(a, ledi2c_pkg::OFS_LIMIT0)) begin
			return ledi2c_pkg::SZ_LIMIT;
		end else if (in_bank(a, ledi2c_pkg::OFS_READBACK0)) begin
			return ledi2c_pkg::SZ_READBACK;
		end else if (in_bank(a, ledi2c_pkg::OFS_GOAL0)) begin
			return ledi2c_pkg::SZ_GOAL;
		end else if (in_bank(a, ledi2c_pkg::OFS_ADC0)) begin
			return ledi2c_pkg::SZ_ADC;
		end
		return ledi2c_pkg::SZ_NONE;
	endfunction

	function automatic logic [6:0] addr_select(input logic [6:0] p);
		if (p < ledi2c_pkg::ADDR_LOW || p > ledi2c_pkg::ADDR_HIGH) begin
			return ledi2c_pkg::ADDR_DEFAULT;
		end
		return p;
	endfunction

	// ---------------------------------------------------------------
	// Bus events from synchronised lines
	// ---------------------------------------------------------------
	assign rise = s_reg.scl_s & ~s_reg.scl_p;
	assign fall = ~s_reg.scl_s & s_reg.scl_p;
	assign start = s_reg.scl_s & s_reg.scl_p & s_reg.sda_p & ~s_reg.sda_s;
	assign stop = s_reg.scl_s & s_reg.scl_p & ~s_reg.sda_p & s_reg.sda_s;

	// ---------------------------------------------------------------
	// Register read view
	// ---------------------------------------------------------------
	always_comb begin
		rv = 32'h00000000;
		if (s_reg.ra == ledi2c_pkg::OFS_MIN_SUPPLY) begin
			rv = s_reg.min_supply;
		end else if (in_bank(s_reg.ra, ledi2c_pkg::OFS_LIMIT0)) begin
			rv = {16'h0000, s_reg.limit[bank_idx(s_reg.ra,
				ledi2c_pkg::OFS_LIMIT0)]};
		end else if (in_bank(s_reg.ra, ledi2c_pkg::OFS_READBACK0)) begin
			rv = {16'h0000, cur[bank_idx(s_reg.ra,
				ledi2c_pkg::OFS_READBACK0)]};
		end else if (in_bank(s_reg.ra, ledi2c_pkg::OFS_GOAL0)) begin
			rv = s_reg.goal[bank_idx(s_reg.ra, ledi2c_pkg::OFS_GOAL0)];
		end else if (in_bank(s_reg.ra, ledi2c_pkg::OFS_ADC0)) begin
			rv = {16'h0000, s_reg.adc[bank_idx(s_reg.ra,
				ledi2c_pkg::OFS_ADC0)]};
		end
		rsz = reg_size(s_reg.ra);
		in_size = {1'b0, s_reg.bi} < rsz;
		pos = 4'(rsz - 5'h01) - s_reg.bi;
		if (in_size) begin
			rbyte = 8'(rv >> {pos[1:0], 3'b000});
		end else begin
			rbyte = 8'h00;
		end
		lum_zero = 1'b1;
		adc_low = 6'h00;
		for (int i = 0; i < ledi2c_pkg::NCH; i++) begin
			if (s_reg.goal[i][ledi2c_pkg::BRIGHT_MSB:
				ledi2c_pkg::BRIGHT_LSB] != 16'h0000) begin
				lum_zero = 1'b0;
			end
			adc_low = adc_low | s_reg.adc[i][5:0];
		end
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		// Two-stage synchronisers, third stage only for edge finding
		s_next.scl_m = scl_in;
		s_next.scl_s = s_reg.scl_m;
		s_next.scl_p = s_reg.scl_s;
		s_next.sda_m = sda_in;
		s_next.sda_s = s_reg.sda_m;
		s_next.sda_p = s_reg.sda_s;
		s_next.strap_m = addr_strap;
		s_next.strap_s = s_reg.strap_m;
		s_next.own_addr = addr_select(s_reg.strap_s);
		// Millisecond ramp tick and analog refresh
		s_next.ramp_tick = 1'b0;
		if (s_reg.ramp_cnt >= 20'(RAMP_CYC - 1)) begin
			s_next.ramp_cnt = 20'h00000;
			s_next.ramp_tick = 1'b1;
		end else begin
			s_next.ramp_cnt = s_reg.ramp_cnt + 20'h00001;
		end
		if (s_reg.adc_cnt >= 20'(ADC_CYC - 1)) begin
			s_next.adc_cnt = 20'h00000;
			for (int i = 0; i < ledi2c_pkg::NCH; i++) begin
				s_next.adc[i] = {adc_value[i], ledi2c_pkg::ADC_PAD};
			end
		end else begin
			s_next.adc_cnt = s_reg.adc_cnt + 20'h00001;
		end
		s_next.led_en = supply_level > s_reg.min_supply;
		s_next.low_pw = lum_zero;
		s_next.asup = ~lum_zero;
		// Snapshot is copied back once after every reset, but reset also loads the snapshot with the reset values
		if (!s_reg.booted) begin
			s_next.booted = 1'b1;
			s_next.limit = s_reg.snap_limit;
			s_next.min_supply = s_reg.snap_min;
		end
		if (start) begin
			s_next.st = ledi2c_pkg::ST_ADDR;
			s_next.cnt = 3'h0;
			s_next.done = 1'b0;
			s_next.oe_n = 1'b1;
		end else if (stop) begin
			s_next.st = ledi2c_pkg::ST_IDLE;
			s_next.done = 1'b0;
			s_next.oe_n = 1'b1;
		end else begin
			if (rise && (s_reg.st == ledi2c_pkg::ST_ADDR ||
				s_reg.st == ledi2c_pkg::ST_REG ||
				s_reg.st == ledi2c_pkg::ST_WDATA ||
				s_reg.st == ledi2c_pkg::ST_RDATA)) begin
				if (s_reg.st != ledi2c_pkg::ST_RDATA) begin
					s_next.shift = {s_reg.shift[6:0], s_reg.sda_s};
				end
				s_next.cnt = s_reg.cnt + 3'h1;
				if (s_reg.cnt == 3'h7) begin
					s_next.done = 1'b1;
				end
			end
			case (s_reg.st)
				ledi2c_pkg::ST_ADDR: begin
					if (fall && s_reg.done) begin
						s_next.done = 1'b0;
						if (s_reg.shift[7:1] == s_reg.own_addr) begin
							s_next.rw = s_reg.shift[0];
							s_next.bi = 4'h0;
							s_next.oe_n = 1'b0;
							s_next.st = ledi2c_pkg::ST_ACK_ADDR;
						end else begin
							s_next.st = ledi2c_pkg::ST_WAIT;
						end
					end
				end
				ledi2c_pkg::ST_ACK_ADDR: begin
					if (fall) begin
						s_next.cnt = 3'h0;
						if (s_reg.rw) begin
							s_next.shift = rbyte;
							s_next.oe_n = rbyte[7];
							s_next.st = ledi2c_pkg::ST_RDATA;
						end else begin
							s_next.oe_n = 1'b1;
							s_next.st = ledi2c_pkg::ST_REG;
						end
					end
				end
				ledi2c_pkg::ST_REG: begin
					if (fall && s_reg.done) begin
						s_next.done = 1'b0;
						s_next.ra = s_reg.shift;
						s_next.bi = 4'h0;
						s_next.oe_n = 1'b0;
						s_next.st = ledi2c_pkg::ST_ACK_REG;
						if (s_reg.shift == ledi2c_pkg::OFS_STORE) begin
							s_next.snap_limit = s_reg.limit;
							s_next.snap_min = s_reg.min_supply;
						end
					end
				end
				ledi2c_pkg::ST_ACK_REG, ledi2c_pkg::ST_ACK_W: begin
					if (fall) begin
						s_next.oe_n = 1'b1;
						s_next.cnt = 3'h0;
						s_next.st = ledi2c_pkg::ST_WDATA;
					end
				end
				ledi2c_pkg::ST_WDATA: begin
					if (fall && s_reg.done) begin
						s_next.done = 1'b0;
						if (in_size) begin
							if (s_reg.ra == ledi2c_pkg::OFS_MIN_SUPPLY) begin
								s_next.min_supply[{pos[1:0], 3'b000} +: 8] =
									s_reg.shift;
							end else if (in_bank(s_reg.ra,
								ledi2c_pkg::OFS_LIMIT0)) begin
								s_next.limit[bank_idx(s_reg.ra,
									ledi2c_pkg::OFS_LIMIT0)]
									[{pos[0], 3'b000} +: 8] = s_reg.shift;
							end else if (in_bank(s_reg.ra,
								ledi2c_pkg::OFS_GOAL0)) begin
								s_next.goal[bank_idx(s_reg.ra,
									ledi2c_pkg::OFS_GOAL0)]
									[{pos[1:0], 3'b000} +: 8] = s_reg.shift;
							end
						end
						if (s_reg.bi != ledi2c_pkg::BYTE_IDX_MAX) begin
							s_next.bi = s_reg.bi + 4'h1;
						end
						s_next.oe_n = 1'b0;
						s_next.st = ledi2c_pkg::ST_ACK_W;
					end
				end
				ledi2c_pkg::ST_RDATA: begin
					if (fall) begin
						if (s_reg.done) begin
							s_next.done = 1'b0;
							s_next.oe_n = 1'b1;
							if (s_reg.bi != ledi2c_pkg::BYTE_IDX_MAX) begin
								s_next.bi = s_reg.bi + 4'h1;
							end
							s_next.st = ledi2c_pkg::ST_ACK_R;
						end else begin
							s_next.shift = {s_reg.shift[6:0], 1'b0};
							s_next.oe_n = s_reg.shift[6];
						end
					end
				end
				ledi2c_pkg::ST_ACK_R: begin
					if (rise) begin
						if (s_reg.sda_s) begin
							s_next.st = ledi2c_pkg::ST_WAIT;
						end else begin
							s_next.done = 1'b1;
						end
					end else if (fall && s_reg.done) begin
						s_next.done = 1'b0;
						s_next.cnt = 3'h0;
						s_next.shift = rbyte;
						s_next.oe_n = rbyte[7];
						s_next.st = ledi2c_pkg::ST_RDATA;
					end
				end
				ledi2c_pkg::ST_IDLE, ledi2c_pkg::ST_WAIT: begin
					s_next.oe_n = 1'b1;
				end
				default: begin
					s_next.st = ledi2c_pkg::ST_IDLE;
					s_next.oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.scl_m <= 1'b1;
			s_reg.scl_s <= 1'b1;
			s_reg.scl_p <= 1'b1;
			s_reg.sda_m <= 1'b1;
			s_reg.sda_s <= 1'b1;
			s_reg.sda_p <= 1'b1;
			s_reg.own_addr <= ledi2c_pkg::ADDR_DEFAULT;
			s_reg.st <= ledi2c_pkg::ST_IDLE;
			s_reg.oe_n <= 1'b1;
			s_reg.goal <= {ledi2c_pkg::NCH{ledi2c_pkg::RST_GOAL}};
			s_reg.limit <= {ledi2c_pkg::NCH{ledi2c_pkg::RST_LIMIT}};
			s_reg.snap_limit <= {ledi2c_pkg::NCH{ledi2c_pkg::RST_LIMIT}};
			s_reg.min_supply <= ledi2c_pkg::RST_MIN_SUPPLY;
			s_reg.snap_min <= ledi2c_pkg::RST_MIN_SUPPLY;
			s_reg.low_pw <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// ---------------------------------------------------------------
	// Channel ramps
	// ---------------------------------------------------------------
	for (genvar i = 0; i < ledi2c_pkg::NCH; i++) begin : g_ch
		ledi2c_ramp u_ramp (
			.clk(clk),
			.rst_n(rst_n),
			.ce(ce),
			.tick(s_reg.ramp_tick),
			.enable(s_reg.led_en),
			.target(s_reg.goal[i][ledi2c_pkg::BRIGHT_MSB:
				ledi2c_pkg::BRIGHT_LSB]),
			.rate(s_reg.goal[i][ledi2c_pkg::RATE_MSB:ledi2c_pkg::RATE_LSB]),
			.limit(s_reg.limit[i]),
			.current(cur[i])
		);
	end

	// Open-drain data: only ever pulls low; clock line has no driver
	assign sda_out = 1'b0;
	assign sda_oe_n = s_reg.oe_n;
	assign channel_current = cur;
	assign led_enable = s_reg.led_en;
	assign low_power = s_reg.low_pw;
	assign analog_supply_out = s_reg.asup;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n || !ce);

	property p_start_seen;
		start |=> s_reg.st == ledi2c_pkg::ST_ADDR && s_reg.oe_n;
	endproperty
	a_start_seen: assert property (p_start_seen)
		else $error("start not followed by address phase");

	property p_stop_seen;
		stop |=> s_reg.st == ledi2c_pkg::ST_IDLE && s_reg.oe_n;
	endproperty
	a_stop_seen: assert property (p_stop_seen)
		else $error("stop did not return to idle");

	property p_addr_ack;
		s_reg.st == ledi2c_pkg::ST_ADDR && fall && s_reg.done &&
			s_reg.shift[7:1] == s_reg.own_addr
			|=> !s_reg.oe_n && s_reg.st == ledi2c_pkg::ST_ACK_ADDR;
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("own address not acknowledged");

	property p_addr_nack;
		s_reg.st == ledi2c_pkg::ST_ADDR && fall && s_reg.done &&
			s_reg.shift[7:1] != s_reg.own_addr
			|=> s_reg.oe_n && s_reg.st == ledi2c_pkg::ST_WAIT;
	endproperty
	a_addr_nack: assert property (p_addr_nack)
		else $error("foreign address acknowledged");

	property p_reg_ack;
		s_reg.st == ledi2c_pkg::ST_REG && fall && s_reg.done
			|=> !s_reg.oe_n && s_reg.ra == $past(s_reg.shift) &&
			s_reg.bi == 4'h0;
	endproperty
	a_reg_ack: assert property (p_reg_ack)
		else $error("register address not taken or not acked");

	property p_wdata_ack;
		s_reg.st == ledi2c_pkg::ST_WDATA && fall && s_reg.done
			|=> s_reg.st == ledi2c_pkg::ST_ACK_W && !s_reg.oe_n;
	endproperty
	a_wdata_ack: assert property (p_wdata_ack)
		else $error("data byte not acknowledged");

	property p_nack_release;
		s_reg.st == ledi2c_pkg::ST_ACK_R && rise && s_reg.sda_s && !start
			|=> s_reg.oe_n && s_reg.st == ledi2c_pkg::ST_WAIT;
	endproperty
	a_nack_release: assert property (p_nack_release)
		else $error("data line not released after no-ack");

	property p_oe_on_fall;
		$changed(s_reg.oe_n) && !$past(start) && !$past(stop)
			|-> $past(fall);
	endproperty
	a_oe_on_fall: assert property (p_oe_on_fall)
		else $error("data line changed outside clock low");

	property p_addr_default;
		(s_reg.strap_s < ledi2c_pkg::ADDR_LOW ||
			s_reg.strap_s > ledi2c_pkg::ADDR_HIGH) [*2]
			|-> s_reg.own_addr == ledi2c_pkg::ADDR_DEFAULT;
	endproperty
	a_addr_default: assert property (p_addr_default)
		else $error("reserved strap not replaced by default");

	property p_low_power;
		lum_zero [*2] |-> low_power && !analog_supply_out;
	endproperty
	a_low_power: assert property (p_low_power)
		else $error("low power not entered with all targets zero");

	property p_led_off;
		(supply_level <= s_reg.min_supply) [*2] |-> !led_enable;
	endproperty
	a_led_off: assert property (p_led_off)
		else $error("outputs enabled below minimum supply");

	property p_adc_left;
		adc_low == 6'h00;
	endproperty
	a_adc_left: assert property (p_adc_left)
		else $error("analog result not left-justified");

	c_addr_ack: cover property (s_reg.st == ledi2c_pkg::ST_ACK_ADDR);
	c_write_byte: cover property (s_reg.st == ledi2c_pkg::ST_ACK_W);
	c_read_nack: cover property (s_reg.st == ledi2c_pkg::ST_ACK_R && rise &&
		s_reg.sda_s);
	c_store: cover property (s_reg.st == ledi2c_pkg::ST_ACK_REG &&
		s_reg.ra == ledi2c_pkg::OFS_STORE);

endmodule

// ---- test/ledi2c_master.sv ----
// I2C master model that drives the slave's bus pins
`timescale 1ns/100ps
module ledi2c_master (
	input wire logic clk,
	input wire logic sda_bus,
	output logic scl,
	output logic sda_drv
);
	// ---------------------------------------------------------------
	// Bus phases; a released line is pulled high
	// ---------------------------------------------------------------
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic start();
		sda_drv = 1'b1;
		cyc(2);
		scl = 1'b1;
		cyc(4);
		sda_drv = 1'b0;
		cyc(4);
		scl = 1'b0;
		cyc(1);
	endtask
	task automatic stop();
		sda_drv = 1'b0;
		cyc(2);
		scl = 1'b1;
		cyc(4);
		sda_drv = 1'b1;
		cyc(4);
	endtask
	// Bit time of 8 clocks; data moves one clock after the clock fall
	task automatic bit_io(input logic b, output logic r);
		sda_drv = b;
		cyc(2);
		scl = 1'b1;
		cyc(3);
		r = sda_bus;
		cyc(2);
		scl = 1'b0;
		cyc(1);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack_in,
		output logic [7:0] r, output logic ack_out);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r[i]);
		bit_io(ack_in, ack_out);
	endtask
endmodule

// ---- test/test_ledi2c_slave.sv ----
// Self-checking bench of the LED driver I2C slave
`timescale 1ns/100ps
module test_ledi2c_slave;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic scl, sda_drv, sda_out, sda_oe_n, sda_bus, a;
	logic [7:0] r;
	logic [6:0] addr_strap = 7'h28;
	logic [31:0] supply_level = 32'h00060000;
	logic [4:0][9:0] adc_value = 50'h0;
	logic [4:0][15:0] channel_current;
	logic led_enable, low_power, analog_supply_out;
	int errors = 0;
	int checks_done = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	assign sda_bus = sda_drv & (sda_oe_n | sda_out);
	ledi2c_master ledi2c_master_inst (.clk(clk), .sda_bus(sda_bus),
		.scl(scl), .sda_drv(sda_drv));
	ledi2c_slave #(.RAMP_CYC(20), .ADC_CYC(30)) ledi2c_slave_inst (
		.clk(clk), .rst_n(rst_n), .ce(ce), .scl_in(scl),
		.sda_in(sda_bus), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.addr_strap(addr_strap), .supply_level(supply_level),
		.adc_value(adc_value), .channel_current(channel_current),
		.led_enable(led_enable), .low_power(low_power),
		.analog_supply_out(analog_supply_out));
	// ---------------------------------------------------------------
	// Checking and transfer tasks
	// ---------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic head(input logic [6:0] ad, input logic [7:0] ra);
		ledi2c_master_inst.start();
		ledi2c_master_inst.xfer({ad, 1'b0}, 1'b1, r, a);
		check(a, 1'h0);
		ledi2c_master_inst.xfer(ra, 1'b1, r, a);
		check(a, 1'h0);
	endtask
	task automatic wr(input logic [7:0] ra, input int n, input logic [31:0] d);
		head(7'h28, ra);
		for (int i = n - 1; i >= 0; i--) begin
			ledi2c_master_inst.xfer(d[8*i +: 8], 1'b1, r, a);
			check(a, 1'h0);
		end
		ledi2c_master_inst.stop();
	endtask
	task automatic rd(input logic [7:0] ra, input int n, input logic [31:0] e);
		logic [31:0] v;
		v = 32'h0;
		head(7'h28, ra);
		ledi2c_master_inst.start();
		ledi2c_master_inst.xfer({7'h28, 1'b1}, 1'b1, r, a);
		check(a, 1'h0);
		for (int i = n - 1; i >= 0; i--) begin
			ledi2c_master_inst.xfer(8'hff, i == 0, r, a);
			v = {v[23:0], r};
		end
		ledi2c_master_inst.cyc(3);
		check(sda_oe_n, 1'h1);
		ledi2c_master_inst.stop();
		check(v, e);
	endtask
	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		ledi2c_master_inst.cyc(12);
		rst_n = 1'b1;
		ledi2c_master_inst.cyc(6);
		check(led_enable, 1'h1);
		check(low_power, 1'h1);
		ledi2c_master_inst.start();
		ledi2c_master_inst.xfer(8'h52, 1'b1, r, a);
		check(a, 1'h1);
		ledi2c_master_inst.stop();
		rd(8'h22, 4, 32'h00058000);
		wr(8'h30, 2, 32'h0000ffff);
		wr(8'h3a, 4, 32'h01000040);
		check(channel_current[0] < 16'h0080, 1'h1);
		ledi2c_master_inst.cyc(100);
		check(channel_current[0], 16'h00ff);
		wr(8'h3a, 4, 32'h8000ffff);
		check(analog_supply_out, 1'h1);
		ledi2c_master_inst.cyc(60);
		check(channel_current[0], 16'h7fff);
		for (int i = 1; i < 5; i++)
			check(channel_current[i], 16'h0000);
		rd(8'h3a, 4, 32'h8000ffff);
		rd(8'h35, 2, 32'h00007fff);
		supply_level = 32'h00050000;
		ledi2c_master_inst.cyc(4);
		check(led_enable, 1'h0);
		check(channel_current[0], 16'h0000);
		wr(8'h3a, 4, 32'h0000ffff);
		ledi2c_master_inst.cyc(2);
		check(low_power, 1'h1);
		wr(8'h22, 4, 32'h00040000);
		ledi2c_master_inst.cyc(2);
		check(led_enable, 1'h1);
		head(7'h28, 8'h03);
		ledi2c_master_inst.stop();
		rst_n = 1'b0;
		ledi2c_master_inst.cyc(3);
		check(led_enable, 1'h0);
		rst_n = 1'b1;
		ledi2c_master_inst.cyc(6);
		check(led_enable, 1'h0);
		rd(8'h22, 4, 32'h00058000);
		ce = 1'b0;
		supply_level = 32'h00060000;
		ledi2c_master_inst.cyc(4);
		check(led_enable, 1'h0);
		ce = 1'b1;
		ledi2c_master_inst.cyc(2);
		check(led_enable, 1'h1);
		adc_value = {10'h001, 10'h3ff, 10'h200, 10'h155, 10'h0aa};
		ledi2c_master_inst.cyc(40);
		for (int i = 0; i < 5; i++)
			rd(8'h41 + 8'(i), 2, {16'h0000, adc_value[i], 6'h00});
		addr_strap = 7'h7a;
		ledi2c_master_inst.cyc(8);
		head(7'h55, 8'h22);
		ledi2c_master_inst.stop();
		print_verdict();
	end
endmodule
